// File: design/dig_consts.vh
// constants for the idle/geometry/queued non-data command interpreter
// assumes command-block registers are presented in parallel with a one-cycle command strobe
// Summary of operation
// - immediate-idle opcode enters Idle at once and completes with no timer wait.
// - entering Idle spins spindle up unless it already turns.
// - in Idle the media spins and new commands are accepted without delay.
// - immediate idle leaves standby timeout value and its enable untouched.
// - geometry opcode latches sectors per track and heads minus one.
// - sectors from sector count, heads minus one from device/head low nibble.
// - sector count zero means zero sectors per track, not 256.
// - current geometry is shown in the identify current-geometry words.
// - geometry persists until next geometry command, a reverting soft reset or power loss.
// - soft reset clears geometry only when revert-to-defaults option is set.
// - queued non-data command behaviour follows the selected subcommand.
// - subcommands 0h queue abort and 1h deadline handling are supported.
// - subcommand from feature bits 3-0, parameters in bits 7-4.
`ifndef DIG_CONSTS_VH
`define DIG_CONSTS_VH
`define DIG_OP_IDLE_IMM_A   8'hE1
`define DIG_OP_IDLE_IMM_B   8'h95
`define DIG_OP_INIT_GEOM    8'h91
`define DIG_OP_NCQ_NONDATA  8'h63
`define DIG_SUB_ABORT       4'h0
`define DIG_SUB_DEADLINE    4'h1
`define DIG_ABORT_TYPE_MAX  4'h3
`define DIG_ERR_ABORTED     2
`define DIG_ERR_UNCORRECTABLE  6
`define DIG_ERR_SECT_NOT_FOUND 4
`define DIG_ST_BUSY         7
`define DIG_ST_READY        6
`define DIG_ST_SEEK_DONE    4
`define DIG_ST_ERR          0
`define DIG_GEOM_SECT_RST   8'h00
`define DIG_GEOM_HEAD_RST   4'h0
`define DIG_SPINUP_CYCLES   16'h0010
`endif

// File: design/dig_spin_ctl.v
// spindle model: spin-up sequence from stopped to at-speed
// assumes a start request pulse; reports at-speed as a level
`timescale 1ns/1ps
`include "dig_consts.vh"
module dig_spin_ctl #(
	parameter [15:0] SPINUP_CYCLES = `DIG_SPINUP_CYCLES
) (
	// clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// control
	input  wire        spin_req,
	output reg         at_speed_q,
	output reg         spinning_up_q
);
	reg [15:0] cnt_q;
	always @(posedge clk) begin
		if (sys_rst) begin
			at_speed_q    <= 1'b0;
			spinning_up_q <= 1'b0;
			cnt_q         <= 16'h0000;
		end else if (spinning_up_q) begin
			if (cnt_q == SPINUP_CYCLES - 16'h0001) begin
				spinning_up_q <= 1'b0;
				at_speed_q    <= 1'b1;
			end
			cnt_q <= cnt_q + 16'h0001;
		end else if (spin_req && !at_speed_q) begin
			spinning_up_q <= 1'b1;
			cnt_q         <= 16'h0000;
		end
	end
endmodule // dig_spin_ctl

// File: design/dig_cmd_top.v
// command interpreter for immediate idle, geometry set and queued non-data
// assumes host task file arrives as parallel bytes qualified by cmd_stb, one clock
// soft reset controls may come from the host side, so they are resynchronised
`timescale 1ns/1ps
`include "dig_consts.vh"
module dig_cmd_top (
	// clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	input  wire       soft_rst,
	input  wire       revert_defaults,
	// command block in
	input  wire       cmd_stb,
	input  wire [7:0] cmd_code,
	input  wire [7:0] cmd_feature,
	input  wire [7:0] cmd_sect_cnt,
	input  wire [7:0] cmd_sect_num,
	input  wire [7:0] cmd_dev_head,
	// standby timer settings held elsewhere
	input  wire [7:0] standby_timeout,
	input  wire       standby_enable,
	// queue state
	input  wire       ncq_enabled,
	input  wire [4:0] max_queue_tag,
	// results
	output reg  [7:0] command_error_flags_q,
	output reg  [7:0] command_status_flags_q,
	output reg        cmd_done_q,
	output reg        idle_mode_q,
	output reg  [7:0] geom_sectors_q,
	output reg  [3:0] geom_heads_m1_q,
	output reg  [15:0] ident_word54_q,
	output reg  [15:0] ident_word55_q,
	output reg  [15:0] ident_word56_q,
	output reg        queue_abort_q,
	output reg  [3:0] abort_type_q,
	output reg  [4:0] abort_target_slot_q,
	output reg        deadline_req_q,
	output reg  [3:0] deadline_param_q,
	output reg  [7:0] timeout_seen_q,
	output reg        timeout_en_seen_q
);
	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_SPIN = 2'd1;
	localparam [1:0] S_DONE = 2'd2;

	reg  [1:0] state_q;
	reg        pend_err_q;
	reg        spin_req_q;
	wire       at_speed;
	wire       spinning_up;
	// two-stage capture of the soft reset controls
	reg        soft_rst_m_q;
	reg        soft_rst_s_q;
	reg        revert_m_q;
	reg        revert_s_q;

	wire       is_idle     = (cmd_code == `DIG_OP_IDLE_IMM_A) || (cmd_code == `DIG_OP_IDLE_IMM_B);
	wire [3:0] sub         = cmd_feature[3:0];
	wire [3:0] subprm      = cmd_feature[7:4];
	wire [4:0] tag         = cmd_sect_cnt[7:3];
	wire [4:0] target_slot = cmd_sect_num[7:3];

	// command decode, only acted on in the cycle a command is taken
	wire       cmd_take    = cmd_stb && (state_q == S_IDLE);
	wire       is_geom     = (cmd_code == `DIG_OP_INIT_GEOM);
	wire       is_ncq      = (cmd_code == `DIG_OP_NCQ_NONDATA);
	// abort refusals: queue off, unknown type, bad target on a selected abort
	wire       type_bad    = (subprm > `DIG_ABORT_TYPE_MAX);
	wire       sel_abort   = (subprm == `DIG_ABORT_TYPE_MAX);
	wire       target_bad  = (target_slot == tag) || (target_slot > max_queue_tag);
	wire       abort_bad   = !ncq_enabled || type_bad || (sel_abort && target_bad);
	// geometry loaded by its command, dropped only by sys_rst or a reverting soft reset
	wire       geom_load   = cmd_take && is_geom;
	wire       geom_clear  = soft_rst_s_q && revert_s_q;
	// logical heads reported as heads minus one plus one
	wire [4:0] heads_now   = {1'b0, geom_heads_m1_q} + 5'h01;

	// spindle model; at speed stays set once reached
	dig_spin_ctl #(
		.SPINUP_CYCLES (`DIG_SPINUP_CYCLES)
	) u_spin (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.spin_req      (spin_req_q),
		.at_speed_q    (at_speed),
		.spinning_up_q (spinning_up)
	);

	// command sequencer: take, optional spin-up, completion
	always @(posedge clk) begin
		if (sys_rst) begin
			state_q                <= S_IDLE;
			pend_err_q             <= 1'b0;
			spin_req_q             <= 1'b0;
			command_error_flags_q  <= 8'h00;
			command_status_flags_q <= 8'h00;
			cmd_done_q             <= 1'b0;
			idle_mode_q            <= 1'b0;
			queue_abort_q          <= 1'b0;
			abort_type_q           <= 4'h0;
			abort_target_slot_q    <= 5'h00;
			deadline_req_q         <= 1'b0;
			deadline_param_q       <= 4'h0;
			timeout_seen_q         <= 8'h00;
			timeout_en_seen_q      <= 1'b0;
		end else begin
			cmd_done_q     <= 1'b0;
			queue_abort_q  <= 1'b0;
			deadline_req_q <= 1'b0;
			spin_req_q     <= 1'b0;
			// timer settings only mirrored, never written here
			timeout_seen_q    <= standby_timeout;
			timeout_en_seen_q <= standby_enable;
			command_status_flags_q[`DIG_ST_READY]     <= at_speed;
			command_status_flags_q[`DIG_ST_SEEK_DONE] <= at_speed;
			case (state_q)
			S_IDLE: begin
				if (cmd_stb) begin
					// a new command clears the previous outcome
					command_status_flags_q[`DIG_ST_BUSY] <= 1'b1;
					command_status_flags_q[`DIG_ST_ERR]  <= 1'b0;
					command_error_flags_q <= 8'h00;
					pend_err_q <= 1'b0;
					state_q    <= S_DONE;
					if (is_idle) begin
						idle_mode_q <= 1'b1;
						if (!at_speed) begin
							spin_req_q <= 1'b1;
							state_q    <= S_SPIN;
						end
					end else if (is_geom) begin
						// geometry latch handled below
					end else if (is_ncq) begin
						case (sub)
						`DIG_SUB_ABORT: begin
							if (abort_bad)
								pend_err_q <= 1'b1;
							else begin
								queue_abort_q       <= 1'b1;
								abort_type_q        <= subprm;
								// target slot only has meaning for a selected abort
								if (sel_abort)
									abort_target_slot_q <= target_slot;
							end
						end
						`DIG_SUB_DEADLINE: begin
							if (!ncq_enabled)
								pend_err_q <= 1'b1;
							else begin
								deadline_req_q   <= 1'b1;
								deadline_param_q <= subprm;
							end
						end
						default: pend_err_q <= 1'b1;
						endcase
					end else begin
						pend_err_q <= 1'b1;
					end
				end
			end
			S_SPIN: begin
				// busy holds until the spindle reports at speed
				if (at_speed && !spinning_up && !spin_req_q)
					state_q <= S_DONE;
			end
			S_DONE: begin
				// release busy and post the outcome; no media access, so data errors stay clear
				command_status_flags_q[`DIG_ST_BUSY] <= 1'b0;
				command_status_flags_q[`DIG_ST_ERR]  <= pend_err_q;
				command_error_flags_q[`DIG_ERR_ABORTED] <= pend_err_q;
				command_error_flags_q[`DIG_ERR_UNCORRECTABLE]  <= 1'b0;
				command_error_flags_q[`DIG_ERR_SECT_NOT_FOUND] <= 1'b0;
				cmd_done_q <= 1'b1;
				state_q    <= S_IDLE;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

	// soft reset controls from the host side; two flops before use
	always @(posedge clk) begin
		if (sys_rst) begin
			soft_rst_m_q <= 1'b0;
			soft_rst_s_q <= 1'b0;
			revert_m_q   <= 1'b0;
			revert_s_q   <= 1'b0;
		end else begin
			soft_rst_m_q <= soft_rst;
			soft_rst_s_q <= soft_rst_m_q;
			revert_m_q   <= revert_defaults;
			revert_s_q   <= revert_m_q;
		end
	end

	// geometry survives sys_rst-free operation; cleared only per soft reset option
	always @(posedge clk) begin
		if (sys_rst) begin
			geom_sectors_q  <= `DIG_GEOM_SECT_RST;
			geom_heads_m1_q <= `DIG_GEOM_HEAD_RST;
		end else if (geom_clear) begin
			geom_sectors_q  <= `DIG_GEOM_SECT_RST;
			geom_heads_m1_q <= `DIG_GEOM_HEAD_RST;
		end else if (geom_load) begin
			geom_sectors_q  <= cmd_sect_cnt;
			geom_heads_m1_q <= cmd_dev_head[3:0];
		end
	end

	// identify current geometry words
	always @(posedge clk) begin
		if (sys_rst) begin
			ident_word54_q <= 16'h0000;
			ident_word55_q <= 16'h0000;
			ident_word56_q <= 16'h0000;
		end else begin
			ident_word54_q <= 16'h0000;
			ident_word55_q <= {11'h000, heads_now};
			ident_word56_q <= {8'h00, geom_sectors_q};
		end
	end
endmodule // dig_cmd_top

// File: tb/dig_host_model.sv
// host side: presents one task-file command per request, holds strobe until taken
// assumes busy is status bit 7 of the device, sampled on the rising edge
`timescale 1ns/1ps
module dig_host_model (
	input  wire        clk,
	input  wire        req,
	input  wire [39:0] cmd_in,
	input  wire        busy,
	output reg         cmd_stb = 1'b0,
	output reg  [39:0] cmd_blk = 40'h0
);
	always @(posedge clk) begin
		if (cmd_stb && !busy) begin
			cmd_stb <= 1'b0;
			cmd_blk <= ~cmd_blk; // released lines carry junk
		end else if (req && !cmd_stb) begin
			cmd_stb <= 1'b1;
			cmd_blk <= cmd_in; // caller keeps heads to 4 bits and tags unique
		end
	end
endmodule // dig_host_model

// File: tb/dig_cmd_top_assertions.sv
// checker for command timing and results
// bound into dig_cmd_top, sees its ports only
`timescale 1ns/1ps
module dig_cmd_top_assertions (
	input wire        clk, sys_rst, cmd_stb, ncq_enabled, cmd_done_q, idle_mode_q, queue_abort_q, deadline_req_q,
	input wire [7:0]  cmd_code, cmd_feature, cmd_sect_cnt, cmd_dev_head, geom_sectors_q,
	input wire [7:0]  command_error_flags_q, command_status_flags_q,
	input wire [3:0]  geom_heads_m1_q, abort_type_q,
	input wire [15:0] ident_word54_q, ident_word56_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire tk = cmd_stb & ~command_status_flags_q[7];
	wire idl = cmd_code == 8'hE1 || cmd_code == 8'h95;
	wire ncq = tk && cmd_code == 8'h63 && ncq_enabled;
	wire [3:0] dh = cmd_dev_head[3:0];
	sequence done_ok; cmd_done_q && !command_error_flags_q[2]; endsequence
	sequence done_bad; cmd_done_q && command_error_flags_q[2] && command_status_flags_q[0]; endsequence
	a_geom_latched: assert property (tk && cmd_code == 8'h91 |=> geom_sectors_q == $past(cmd_sect_cnt) &&
		geom_heads_m1_q == $past(dh) ##1 done_ok) else $error("geometry not latched");
	a_ident_follows: assert property (cmd_done_q |=> ident_word56_q == {8'h00, geom_sectors_q} &&
		ident_word54_q == 16'h0000) else $error("ident words stale");
	a_idle_ready: assert property (tk && idl && command_status_flags_q[6] |-> ##2 done_ok ##0 idle_mode_q)
		else $error("idle late");
	a_idle_spinup: assert property (tk && idl && !command_status_flags_q[6] |-> ##[16:40] cmd_done_q && idle_mode_q)
		else $error("spin-up idle missing");
	a_bad_opcode: assert property (tk && !(cmd_code inside {8'hE1, 8'h95, 8'h91, 8'h63}) |-> ##2 done_bad)
		else $error("bad opcode not refused");
	a_deadline_pulse: assert property (ncq && cmd_feature[3:0] == 4'h1 |-> ##[1:2] deadline_req_q)
		else $error("no deadline request");
	a_abort_all: assert property (ncq && cmd_feature == 8'h00 |-> ##[1:2] queue_abort_q && abort_type_q == 4'h0)
		else $error("no queue abort");
	a_done_idle: assert property (cmd_done_q |-> !command_status_flags_q[7]) else $error("done while busy");
endmodule // dig_cmd_top_assertions
bind dig_cmd_top dig_cmd_top_assertions i_dig_cmd_top_assertions (.*);

// File: tb/dig_cmd_top_test.sv
// testbench: commands through the host model, results checked at the ports
// assumes done two cycles after take once the spindle is at speed
`timescale 1ns/1ps
module dig_cmd_top_test;
	reg clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, revert_defaults = 1'b0, req = 1'b0;
	reg standby_enable = 1'b1, ncq_enabled = 1'b1, qa, dl;
	reg [7:0] standby_timeout = 8'h3C;
	reg [4:0] max_queue_tag = 5'h07;
	reg [39:0] blk = 40'h0;
	wire cmd_stb, cmd_done_q, idle_mode_q, queue_abort_q, deadline_req_q, timeout_en_seen_q;
	wire [39:0] cb;
	wire [7:0] cmd_code, cmd_feature, cmd_sect_cnt, cmd_sect_num, cmd_dev_head;
	wire [7:0] command_error_flags_q, command_status_flags_q, geom_sectors_q, timeout_seen_q;
	wire [3:0] geom_heads_m1_q, abort_type_q, deadline_param_q;
	wire [4:0] abort_target_slot_q;
	wire [15:0] ident_word54_q, ident_word55_q, ident_word56_q;
	int err_total = 0, tests_run = 0, cyc, i;
	assign {cmd_code, cmd_feature, cmd_sect_cnt, cmd_sect_num, cmd_dev_head} = cb;
	initial forever #20 clk = ~clk;
	dig_host_model i_dig_host_model (.clk(clk), .req(req), .cmd_in(blk), .busy(command_status_flags_q[7]),
		.cmd_stb(cmd_stb), .cmd_blk(cb));
	dig_cmd_top i_dig_cmd_top (.*);
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cmd(input [39:0] b, input bad);
		@(posedge clk);
		req <= 1'b1;
		blk <= b;
		@(posedge clk);
		req <= 1'b0;
		cyc = 0;
		qa = 0;
		dl = 0;
		while (cmd_done_q !== 1'b1 && cyc < 80) begin
			@(posedge clk);
			#1;
			cyc++;
			qa |= queue_abort_q;
			dl |= deadline_req_q;
		end
		if (cyc == 80) chk("done", 0, 1);
		chk("aborted", command_error_flags_q[2], bad);
		chk("err", command_status_flags_q[0], bad);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		finish_test;
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		cmd({8'hE1, 32'h0}, 0);
		chk("spin-up", cyc > 17, 1);
		chk("ready", {command_status_flags_q[6], command_status_flags_q[4]}, 2'b11);
		chk("idle", idle_mode_q, 1);
		for (i = 0; i < 2; i++) begin
			cmd({i ? 8'h95 : 8'hE1, 32'h0}, 0);
			chk("idle fast", cyc, 2);
		end
		chk("timeout", timeout_seen_q, 8'h3C);
		chk("timeout en", timeout_en_seen_q, 1);
		cmd({8'h91, 24'h0, 8'hAF}, 0);
		chk("sectors", geom_sectors_q, 0);
		chk("heads", geom_heads_m1_q, 4'hF);
		cmd({8'h91, 8'h00, 8'h3F, 8'h00, 8'hA3}, 0);
		cmd({8'hE1, 32'h0}, 0);
		chk("kept", {geom_sectors_q, geom_heads_m1_q}, 12'h3F3);
		chk("ident 56", ident_word56_q, 16'h003F);
		chk("ident 55", ident_word55_q, 16'h0004);
		chk("ident 54", ident_word54_q, 16'h0000);
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			revert_defaults <= i[0];
			soft_rst <= 1'b1;
			@(posedge clk);
			soft_rst <= 1'b0;
			repeat (3) @(posedge clk);
			#1;
			chk("soft reset", geom_sectors_q, i ? 0 : 8'h3F);
		end
		for (i = 0; i < 4; i++) begin
			cmd({8'h63, i[3:0], 4'h0, 8'h08, 8'h10, 8'h40}, 0);
			chk("queue abort", {qa, abort_type_q}, {1'b1, i[3:0]});
		end
		chk("target", abort_target_slot_q, 5'h02);
		cmd({8'h63, 8'h40, 8'h08, 8'h10, 8'h40}, 1); // abort type 4
		cmd({8'h63, 8'h30, 8'h08, 8'h08, 8'h40}, 1); // target equals own tag
		cmd({8'h63, 8'h30, 8'h08, 8'h40, 8'h40}, 1); // target above max tag
		cmd({8'h63, 8'h02, 8'h08, 8'h00, 8'h40}, 1); // unknown subcommand
		cmd({8'h00, 32'h0}, 1); // unknown opcode
		cmd({8'h63, 8'h31, 8'h08, 8'h00, 8'h40}, 0);
		chk("deadline", {dl, deadline_param_q}, {1'b1, 4'h3});
		@(posedge clk);
		ncq_enabled <= 1'b0;
		cmd({8'h63, 8'h00, 8'h08, 8'h10, 8'h40}, 1); // queue disabled
		cmd({8'h63, 8'h31, 8'h08, 8'h00, 8'h40}, 1); // deadline with queue disabled
		finish_test;
	end
endmodule // dig_cmd_top_test
